/* File: tb_vme_irq_vector_capture.sv */
// Register level test of the vector capture block.
`timescale 1ns/1ps
// ==========
// Testbench
// ==========
module tb_vme_irq_vector_capture;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr, a;
   logic [31:0] s_axi_wdata, rdat, exp_lvl [1:5];
   logic [3:0] s_axi_wstrb, wait_cycles;
   logic [5:1] vme_level_bit_n, en;
   logic [7:0] vec_base;
   logic berr_en;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire iack_req, iack_done, iack_berr, pci_irq;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [2:0] iack_level;
   wire [7:0] iack_vector;
   int n_mismatch, compares, cyc, k;
   vic_top vic_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .vme_level_bit_n, .iack_req, .iack_level, .iack_done,
      .iack_vector, .iack_berr, .pci_irq);
   vic_iack_model vic_iack_model_inst (.aclk, .aresetn, .iack_req, .iack_level, .vec_base,
      .wait_cycles, .berr_en, .iack_done, .iack_vector, .iack_berr);
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task finish_test;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task wr(input logic [11:0] ad, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw;
      ta = 0;
      tw = 0;
      @(posedge aclk);
      s_axi_awaddr <= ad;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ta && tw)) begin
         @(posedge aclk);
         if (!ta && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            ta = 1;
         end
         if (!tw && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            tw = 1;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
   endtask
   task rd(input logic [11:0] ad, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      rdat = s_axi_rdata;
      chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
   endtask
   initial begin
      aclk = 0;
      forever #12.5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc > 20000) begin
         n_mismatch++;
         finish_test;
      end
   end
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, vec_base, wait_cycles, berr_en} = 69'h0;
      s_axi_wstrb = 4'hF;
      vme_level_bit_n = 5'h1F;
      for (int n = 1; n <= 5; n++) exp_lvl[n] = 32'h0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      // Mapped places read zero after reset, the gap between them is refused.
      for (int i = 0; i < 14; i++) begin
         a = 12'h300 + 12'(i * 4);
         rd(a, (i < 3 || i > 8) ? 2'h0 : 2'h2);
         chk("reset value", rdat, 32'h0);
      end
      wr(12'h324, 32'hFFFFFFFF, 2'h0);
      wr(12'h310, 32'hFFFFFFFF, 2'h2);
      rd(12'h324, 2'h0);
      chk("level1", rdat, 32'h0);
      wr(12'h308, 32'h3E, 2'h0);
      vme_level_bit_n <= 5'h00;
      for (int r = 0; r < 3; r++) begin
         vec_base <= 8'h30 + 8'(r * 64);
         berr_en <= (r == 1);
         wait_cycles <= 4'(r * 3);
         en = (r == 2) ? 5'h1B : 5'h1F;
         wr(12'h300, {26'h0, en, 1'b0}, 2'h0);
         wr(12'h304, 32'h3E, 2'h0);
         k = 0;
         do begin
            rd(12'h304, 2'h0);
            k++;
         end while (rdat !== {26'h0, en, 1'b0} && k < 60);
         chk("pending", rdat, {26'h0, en, 1'b0});
         chk("irq", {31'h0, pci_irq}, 32'h1);
         for (int n = 1; n <= 5; n++) begin
            if (en[n]) exp_lvl[n] = {23'h0, r == 1, vec_base + 8'(n)};
            rd(12'h320 + 12'(n * 4), 2'h0);
            chk("level", rdat, exp_lvl[n]);
         end
         // Lines stay low with every enabled level pending, so no acknowledge may start again.
         repeat (6) begin
            @(posedge aclk);
            chk("iack_req", {31'h0, iack_req}, 32'h0);
         end
      end
      wr(12'h308, 32'h0, 2'h0);
      chk("masked irq", {31'h0, pci_irq}, 32'h0);
      vme_level_bit_n <= 5'h1F;
      wr(12'h304, 32'h3E, 2'h0);
      rd(12'h304, 2'h0);
      chk("pending clear", rdat, 32'h0);
      finish_test;
   end
endmodule

/* File: vic_checker.sv */
// Assertions on the ports of the vector capture block.
`timescale 1ns/1ps
// ==========
// Checker
// ==========
module vic_checker (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awready,
   input wire s_axi_bvalid,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire iack_req,
   input wire [2:0] iack_level,
   input wire iack_done,
   input wire pci_irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_lvl_range; iack_req |-> iack_level >= 3'h1 && iack_level <= 3'h5; endproperty
   a_lvl_range: assert property (p_lvl_range) else $error("level out of range");
   property p_lvl_idle; !iack_req |-> iack_level == 3'h0; endproperty
   a_lvl_idle: assert property (p_lvl_idle) else $error("level while idle");
   property p_ack_hold; iack_req && !iack_done |=> iack_req && $stable(iack_level); endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
   property p_ack_drop; iack_req && iack_done |=> !iack_req; endproperty
   a_ack_drop: assert property (p_ack_drop) else $error("ack not ended");
   // A capture or a mask write is the only way the interrupt may come up.
   property p_irq_src; $rose(pci_irq) |->
      ($past(iack_req) && $past(iack_done)) || $rose(s_axi_bvalid);
   endproperty
   a_irq_src: assert property (p_irq_src) else $error("irq without cause");
   property p_aw_block; s_axi_bvalid |-> !s_axi_awready; endproperty
   a_aw_block: assert property (p_aw_block) else $error("write taken early");
   property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar_block: assert property (p_ar_block) else $error("read taken early");
   property p_rresp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rresp: assert property (p_rresp) else $error("read answer late");
   c_done: cover property (iack_req && iack_done);
   c_wait: cover property (iack_req && !iack_done);
   c_irq: cover property ($rose(pci_irq));
endmodule

bind vic_top vic_checker vic_checker_inst (.aclk, .aresetn, .s_axi_awready, .s_axi_bvalid,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .iack_req, .iack_level, .iack_done, .pci_irq);

/* File: vic_defs.vh */
// Address map, field positions and reset values of the vector capture block.
`ifndef VIC_DEFS_VH
`define VIC_DEFS_VH

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define VIC_OFS_ENABLE 12'h300
`define VIC_OFS_PENDING 12'h304
`define VIC_OFS_MASK 12'h308
`define VIC_OFS_LEVEL1 12'h324
`define VIC_OFS_LEVEL2 12'h328
`define VIC_OFS_LEVEL3 12'h32C
`define VIC_OFS_LEVEL4 12'h330
`define VIC_OFS_LEVEL5 12'h334

// ==========================================================================
// Field positions
// ==========================================================================
`define VIC_VEC_MSB 7
`define VIC_VEC_LSB 0
`define VIC_ERR_BIT 8
`define VIC_LVL_LO 1
`define VIC_LVL_HI 5

// ==========================================================================
// Reset values
// ==========================================================================
`define VIC_RST_LEVEL 9'h000
`define VIC_RST_ENABLE 5'h00
`define VIC_RST_PENDING 5'h00
`define VIC_RST_MASK 5'h00

// ==========================================================================
// Bus answers and decode codes
// ==========================================================================
`define VIC_RESP_OKAY 2'h0
`define VIC_RESP_SLVERR 2'h2
`define VIC_SEL_NONE 3'h0
`define VIC_SEL_ENABLE 3'h1
`define VIC_SEL_PENDING 3'h2
`define VIC_SEL_MASK 3'h3
`define VIC_SEL_LEVEL 3'h4

`endif

/* File: vic_iack_model.sv */
// Behavioural interrupter answering acknowledge cycles.
`timescale 1ns/1ps
// ==========
// Interrupter model
// ==========
module vic_iack_model (
   input wire aclk,
   input wire aresetn,
   input wire iack_req,
   input wire [2:0] iack_level,
   input wire [7:0] vec_base,
   input wire [3:0] wait_cycles,
   input wire berr_en,
   output logic iack_done,
   output logic [7:0] iack_vector,
   output logic iack_berr
);
   logic [3:0] cnt;
   // Outside the answer the lines toggle, so a sample at the wrong cycle shows.
   always @(posedge aclk) begin
      iack_done <= 1'b0;
      iack_vector <= ~iack_vector;
      iack_berr <= ~iack_berr;
      if (!aresetn) begin
         cnt <= 4'h0;
         iack_vector <= 8'h00;
         iack_berr <= 1'b0;
      end else if (iack_req && !iack_done) begin
         cnt <= cnt + 4'h1;
         if (cnt == wait_cycles) begin
            iack_done <= 1'b1;
            iack_vector <= vec_base + {5'h00, iack_level};
            iack_berr <= berr_en;
         end
      end else begin
         cnt <= 4'h0;
      end
   end
endmodule

/* File: vic_top.v */
// Per-level interrupt vector capture with an AXI4-Lite register slave.
`timescale 1ns/1ps
`include "vic_defs.vh"


module vic_top (
   input wire aclk,
   input wire aresetn,
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [5:1] vme_level_bit_n,
   output wire iack_req,
   output wire [2:0] iack_level,
   input wire iack_done,
   input wire [7:0] iack_vector,
   input wire iack_berr,
   output wire pci_irq
);

   localparam ST_IDLE = 1'b0;
   localparam ST_ACK = 1'b1;

   // ==========================================================================
   // Address decode
   // ==========================================================================
   function [2:0] reg_sel;
      input [11:0] addr;
      begin
         case ({addr[11:2], 2'b00})
            `VIC_OFS_ENABLE: reg_sel = `VIC_SEL_ENABLE;
            `VIC_OFS_PENDING: reg_sel = `VIC_SEL_PENDING;
            `VIC_OFS_MASK: reg_sel = `VIC_SEL_MASK;
            `VIC_OFS_LEVEL1, `VIC_OFS_LEVEL2, `VIC_OFS_LEVEL3,
            `VIC_OFS_LEVEL4, `VIC_OFS_LEVEL5: reg_sel = `VIC_SEL_LEVEL;
            default: reg_sel = `VIC_SEL_NONE;
         endcase
      end
   endfunction

   // Highest level wins, matching the usual priority of the backplane.
   function [2:0] pick_level;
      input [5:1] elig;
      begin
         if (elig[5]) begin
            pick_level = 3'h5;
         end else if (elig[4]) begin
            pick_level = 3'h4;
         end else if (elig[3]) begin
            pick_level = 3'h3;
         end else if (elig[2]) begin
            pick_level = 3'h2;
         end else begin
            pick_level = 3'h1;
         end
      end
   endfunction

   // ==========================================================================
   // Pin synchroniser
   // ==========================================================================
   reg [5:1] irq_meta_reg;
   reg [5:1] irq_sync_reg;

   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_meta_reg <= 5'h1F;
         irq_sync_reg <= 5'h1F;
      end else begin
         irq_meta_reg <= vme_level_bit_n;
         irq_sync_reg <= irq_meta_reg;
      end
   end

   // ==========================================================================
   // Write channel
   // ==========================================================================
   reg aw_have_reg;
   reg w_have_reg;
   reg [11:0] aw_addr_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;
   reg bvalid_reg;
   reg [1:0] bresp_reg;
   wire do_write;
   wire [2:0] wr_sel;
   wire wr_lane0;

   assign s_axi_awready = !aw_have_reg && !bvalid_reg;
   assign s_axi_wready = !w_have_reg && !bvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;
   assign wr_sel = reg_sel(aw_addr_reg);
   assign wr_lane0 = do_write && w_strb_reg[0];

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         aw_addr_reg <= 12'h000;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `VIC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            if (wr_sel == `VIC_SEL_NONE) begin
               bresp_reg <= `VIC_RESP_SLVERR;
            end else begin
               bresp_reg <= `VIC_RESP_OKAY;
            end
         end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // Control registers
   // ==========================================================================
   reg [5:1] enable_reg;
   reg [5:1] mask_reg;
   reg [5:1] pending_reg;
   reg [5:1] pending_next;
   reg [5:1] capture_set;
   wire [5:1] pending_clr;

   assign pending_clr = (wr_lane0 && wr_sel == `VIC_SEL_PENDING) ?
                        w_data_reg[5:1] : 5'h00;

   always @(posedge aclk) begin
      if (!aresetn) begin
         enable_reg <= `VIC_RST_ENABLE;
         mask_reg <= `VIC_RST_MASK;
      end else if (wr_lane0) begin
         if (wr_sel == `VIC_SEL_ENABLE) begin
            enable_reg <= w_data_reg[5:1];
         end
         if (wr_sel == `VIC_SEL_MASK) begin
            mask_reg <= w_data_reg[5:1];
         end
      end
   end

   // A capture landing in the same cycle as a clear keeps the bit set.
   always @* begin
      pending_next = (pending_reg & ~pending_clr) | capture_set;
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         pending_reg <= `VIC_RST_PENDING;
      end else begin
         pending_reg <= pending_next;
      end
   end

   assign pci_irq = |(pending_reg & mask_reg);

   // ==========================================================================
   // Acknowledge sequencer
   // ==========================================================================
   reg state_reg;
   reg [2:0] level_reg;
   wire [5:1] eligible;

   // A level stays out of arbitration while its pending bit is set.
   assign eligible = ~irq_sync_reg & enable_reg & ~pending_reg;
   assign iack_req = (state_reg == ST_ACK);
   assign iack_level = level_reg;

   always @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= ST_IDLE;
         level_reg <= 3'h0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (|eligible) begin
                  level_reg <= pick_level(eligible);
                  state_reg <= ST_ACK;
               end
            end
            ST_ACK: begin
               if (iack_done) begin
                  state_reg <= ST_IDLE;
                  level_reg <= 3'h0;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   always @* begin
      capture_set = 5'h00;
      if (state_reg == ST_ACK && iack_done) begin
         capture_set[level_reg] = 1'b1;
      end
   end

   // ==========================================================================
   // Per-level vector registers
   // ==========================================================================
   wire [44:0] level_bus;

   genvar g;
   generate
      for (g = `VIC_LVL_LO; g <= `VIC_LVL_HI; g = g + 1) begin : gen_level
         reg [8:0] vec_reg;
         // Only the sequencer writes here; the bus has no path in.
         always @(posedge aclk) begin
            if (!aresetn) begin
               vec_reg <= `VIC_RST_LEVEL;
            end else if (capture_set[g]) begin
               vec_reg[`VIC_VEC_MSB:`VIC_VEC_LSB] <= iack_vector;
               vec_reg[`VIC_ERR_BIT] <= iack_berr;
            end
         end
         assign level_bus[g*9-1 -: 9] = vec_reg;
      end
   endgenerate

   // ==========================================================================
   // Read channel
   // ==========================================================================
   reg rvalid_reg;
   reg [31:0] rdata_reg;
   reg [1:0] rresp_reg;
   reg [31:0] rd_word;
   reg [1:0] rd_resp;
   wire [2:0] rd_sel;
   wire [3:0] rd_idx;

   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign rd_sel = reg_sel(s_axi_araddr);
   // Level n sits at word 0xC8 + n, so the low nibble of the word index is n + 8.
   assign rd_idx = s_axi_araddr[5:2] - 4'h8;

   always @* begin
      rd_word = 32'h00000000;
      rd_resp = `VIC_RESP_OKAY;
      case (rd_sel)
         `VIC_SEL_ENABLE: rd_word = {26'h0000000, enable_reg, 1'b0};
         `VIC_SEL_PENDING: rd_word = {26'h0000000, pending_reg, 1'b0};
         `VIC_SEL_MASK: rd_word = {26'h0000000, mask_reg, 1'b0};
         `VIC_SEL_LEVEL: begin
            case (rd_idx)
               4'h1: rd_word = {23'h000000, level_bus[8:0]};
               4'h2: rd_word = {23'h000000, level_bus[17:9]};
               4'h3: rd_word = {23'h000000, level_bus[26:18]};
               4'h4: rd_word = {23'h000000, level_bus[35:27]};
               4'h5: rd_word = {23'h000000, level_bus[44:36]};
               default: rd_word = 32'h00000000;
            endcase
         end
         default: rd_resp = `VIC_RESP_SLVERR;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= `VIC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_word;
         rresp_reg <= rd_resp;
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

endmodule
